// file: inc/ocfr_pkg.sv
// package: constants and types for the overcurrent fault response block
package ocfr_pkg;
    // =====================================================
    // command codes
    localparam logic [7:0] CMD_OC_RESPONSE = 8'h47; // overcurrent_action_config
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78; // summary status byte
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79; // summary status word
    localparam logic [7:0] CMD_STATUS_IOUT = 8'h7b; // output-current status
    localparam logic [7:0] CFG_RESET = 8'h00; // config value after reset
    // =====================================================
    // config field layout
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    localparam logic [1:0] RESP_CC = 2'h0; // constant-current forever
    localparam logic [1:0] RESP_UNSUP = 2'h1; // no defined behaviour
    localparam logic [1:0] RESP_DEGLITCH = 2'h2; // limit for delay, then retry setting
    localparam logic [1:0] RESP_SHUTDOWN = 2'h3; // shut down at once
    localparam logic [2:0] RETRY_NONE = 3'h0; // latch off
    localparam logic [2:0] RETRY_CONT = 3'h7; // unlimited restarts
    // =====================================================
    // status bit positions
    localparam int SB_NONE_BIT = 0; // none-of-the-above in status byte
    localparam int SB_IOUT_OC_BIT = 4; // overcurrent in status byte
    localparam int SW_IOUT_BIT = 14; // output-current in status word
    localparam int SI_OC_FAULT_BIT = 7; // overcurrent fault in output-current status
    // =====================================================
    // timing
    localparam int DELAY_UNIT_MS = 16; // delay field unit, ms
    localparam int MS_NS = 1000000; // one millisecond in ns
    localparam int CLK_PERIOD_NS = 10; // 100 MHz clock
    localparam int CYCLES_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int MS_CNT_W = 17; // holds CYCLES_PER_MS_DEF
    localparam int TIMER_W = 16; // ms timer width
    // =====================================================
    // channel state, gray along off-run-limit-wait
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_RUN = 3'h1,
        ST_LIMIT = 3'h3,
        ST_RETRY_WAIT = 3'h2,
        ST_LATCHED = 3'h6
    } ocfr_state_type;
endpackage : ocfr_pkg

// file: logic/ocfr_ms_timer.sv
// millisecond down-counter that pulses done when its count expires
`timescale 1ns/1ns
module ocfr_ms_timer #(
    parameter int W = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic ms_tick, // one-cycle pulse each ms
    input wire logic start, // load units and run
    input wire logic [W-1:0] units, // ms to wait
    output logic done // one-cycle pulse at expiry
);
    logic [W-1:0] count_q, count_d; // remaining ms
    logic busy_q, busy_d; // timer running
    logic done_d;

    // =====================================================
    // next count; a start always reloads, even while busy
    always_comb begin
        count_d = count_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start) begin
            count_d = units;
            busy_d = 1'b1;
        end else if (busy_q && count_q == '0) begin
            busy_d = 1'b0;
            done_d = 1'b1;
        end else if (busy_q && ms_tick) begin
            count_d = count_q - W'(1);
        end
    end

    // registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
            busy_q <= 1'b0;
            done <= 1'b0;
        end else begin
            count_q <= count_d;
            busy_q <= busy_d;
            done <= done_d;
        end
    end
endmodule : ocfr_ms_timer

// file: logic/ocfr_fault_response.sv
// overcurrent fault response: config register, status flags, alert and channel control
`timescale 1ns/1ns
// What this block does
// - per-channel rw config byte 0x47, default 0x00
// - fault sets overcurrent and none-above byte bits
// - fault sets output-current bit in status word
// - fault sets channel output-current fault bit
// - fault asserts alert unless masked
// - flag sticky until clear, rerun, restore, reset
// - response 00: limit current, keep running
// - response 10: limit for delay, then retry setting
// - response 11: shut down at once, then retry setting
// - retry 000: stay off until run cycled
// - continuous retry spaced by restart interval
// - delay field counts 16 ms units
// - delay used only by response 10
// - retry 111 selects unlimited restarts
module ocfr_fault_response
    import ocfr_pkg::*;
#(
    parameter int NUM_CH = 2,
    parameter int PAGE_W = 1,
    parameter int CYCLES_PER_MS = ocfr_pkg::CYCLES_PER_MS_DEF
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic cmd_valid, // command strobe
    input wire logic cmd_write, // 1 write, 0 read
    input wire logic [PAGE_W-1:0] cmd_page, // channel select
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    input wire logic clear_faults, // clear-faults command pulse
    input wire logic restore_user_all, // reload config from nonvolatile copy
    input wire logic soft_reset_command, // soft reset pulse
    input wire logic [NUM_CH*8-1:0] nvm_config, // stored config per channel
    input wire logic [NUM_CH-1:0] run_on, // run pin and operation both on
    input wire logic [NUM_CH-1:0] oc_detect, // current at overcurrent_threshold
    input wire logic [NUM_CH-1:0] alert_mask_oc, // alert mask per channel
    input wire logic [ocfr_pkg::TIMER_W-1:0] restart_interval_setting, // ms
    output logic cmd_ack_q, // answer pulse
    output logic cmd_nack_q, // page out of range, unknown code or write to status
    output logic [15:0] cmd_rdata_q,
    output logic [NUM_CH-1:0] output_enable_q, // channel switching
    output logic [NUM_CH-1:0] current_limit_q, // hold current at threshold
    output logic [NUM_CH-1:0] oc_fault_q, // sticky overcurrent flag
    output logic alert_n_q // alert, active low
);
    import ocfr_pkg::*;

    // =====================================================
    // helpers
    function automatic logic [15:0] status_word(input logic flag);
        status_word = '0;
        status_word[SB_NONE_BIT] = flag;
        status_word[SB_IOUT_OC_BIT] = flag;
        status_word[SW_IOUT_BIT] = flag;
    endfunction : status_word

    function automatic ocfr_state_type after_shutdown(input logic [7:0] cfg);
        after_shutdown = (cfg[RETRY_HI:RETRY_LO] == RETRY_CONT) ? ST_RETRY_WAIT : ST_LATCHED;
    endfunction : after_shutdown

    // =====================================================
    // state
    logic [7:0] cfg_q [NUM_CH]; // overcurrent_action_config per channel
    logic [7:0] cfg_d [NUM_CH];
    ocfr_state_type state_q [NUM_CH];
    ocfr_state_type state_d [NUM_CH];
    logic [NUM_CH-1:0] run_prev_q, oc_prev_q; // edge detect
    logic [NUM_CH-1:0] flag_d, oe_d, lim_d;
    logic [NUM_CH-1:0] start_d, timer_done;
    logic [TIMER_W-1:0] units_d [NUM_CH];
    logic [MS_CNT_W-1:0] ms_cnt_q, ms_cnt_d;
    logic ms_tick_q, ms_tick_d;
    logic ack_d, nack_d, alert_n_d;
    logic [15:0] rdata_d;
    logic sel_ok; // page in range
    logic [PAGE_W-1:0] pg;

    // =====================================================
    // millisecond tick
    always_comb begin
        ms_tick_d = (ms_cnt_q == MS_CNT_W'(CYCLES_PER_MS - 1));
        ms_cnt_d = ms_tick_d ? '0 : ms_cnt_q + MS_CNT_W'(1);
    end

    // =====================================================
    // command port: one answer per strobe, next cycle
    always_comb begin
        pg = cmd_page;
        sel_ok = (int'(pg) < NUM_CH);
        ack_d = cmd_valid;
        nack_d = 1'b0;
        rdata_d = cmd_rdata_q;
        if (cmd_valid) begin
            if (!sel_ok) begin
                nack_d = 1'b1;
            end else if (cmd_code == CMD_OC_RESPONSE) begin
                if (!cmd_write) begin
                    rdata_d = {8'h00, cfg_q[pg]};
                end
            end else if (cmd_code == CMD_STATUS_BYTE && !cmd_write) begin
                rdata_d = status_word(oc_fault_q[pg]) & 16'h00ff;
            end else if (cmd_code == CMD_STATUS_WORD && !cmd_write) begin
                rdata_d = status_word(oc_fault_q[pg]);
            end else if (cmd_code == CMD_STATUS_IOUT && !cmd_write) begin
                rdata_d = 16'h0000;
                rdata_d[SI_OC_FAULT_BIT] = oc_fault_q[pg];
            end else begin
                nack_d = 1'b1; // unknown code or read-only status
            end
        end
    end

    // =====================================================
    // per-channel config, flags and response machine
    always_comb begin
        alert_n_d = 1'b1;
        for (int c = 0; c < NUM_CH; c++) begin
            cfg_d[c] = cfg_q[c];
            state_d[c] = state_q[c];
            start_d[c] = 1'b0;
            units_d[c] = restart_interval_setting;
            // config: restore and soft reset reload the stored copy, a write wins
            if (restore_user_all || soft_reset_command) begin
                cfg_d[c] = nvm_config[c*8 +: 8];
            end
            if (cmd_valid && cmd_write && sel_ok && cmd_code == CMD_OC_RESPONSE && int'(pg) == c) begin
                cfg_d[c] = cmd_wdata;
            end
            // sticky flag, a new fault wins over any clear
            flag_d[c] = (oc_fault_q[c] && !(clear_faults || restore_user_all || soft_reset_command
                        || (run_on[c] && !run_prev_q[c])))
                        || (state_q[c] == ST_RUN && oc_detect[c] && !oc_prev_q[c]);
            if (flag_d[c] && !alert_mask_oc[c]) begin
                alert_n_d = 1'b0;
            end
            case (state_q[c])
                ST_OFF: begin
                    if (run_on[c]) begin
                        state_d[c] = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!run_on[c]) begin
                        state_d[c] = ST_OFF;
                    end else if (oc_detect[c]) begin
                        case (cfg_q[c][RESP_HI:RESP_LO])
                            RESP_DEGLITCH: begin
                                start_d[c] = 1'b1;
                                units_d[c] = TIMER_W'(cfg_q[c][DELAY_HI:DELAY_LO]) * TIMER_W'(DELAY_UNIT_MS);
                                state_d[c] = ST_LIMIT;
                            end
                            RESP_SHUTDOWN: begin
                                state_d[c] = after_shutdown(cfg_q[c]);
                                start_d[c] = (after_shutdown(cfg_q[c]) == ST_RETRY_WAIT);
                            end
                            default: begin
                                state_d[c] = ST_RUN;
                            end
                        endcase
                    end
                end
                ST_LIMIT: begin
                    if (!run_on[c]) begin
                        state_d[c] = ST_OFF;
                    end else if (!oc_detect[c]) begin
                        state_d[c] = ST_RUN; // left current limit in time
                    end else if (timer_done[c]) begin
                        state_d[c] = after_shutdown(cfg_q[c]);
                        start_d[c] = (after_shutdown(cfg_q[c]) == ST_RETRY_WAIT);
                    end
                end
                ST_RETRY_WAIT: begin
                    if (!run_on[c]) begin
                        state_d[c] = ST_OFF;
                    end else if (timer_done[c]) begin
                        state_d[c] = ST_RUN;
                    end
                end
                ST_LATCHED: begin
                    if (!run_on[c]) begin
                        state_d[c] = ST_OFF;
                    end
                end
                default: begin
                    state_d[c] = ST_OFF;
                end
            endcase
            oe_d[c] = (state_d[c] == ST_RUN) || (state_d[c] == ST_LIMIT);
            lim_d[c] = oe_d[c] && oc_detect[c] && (cfg_q[c][RESP_HI:RESP_LO] == RESP_CC
                       || cfg_q[c][RESP_HI:RESP_LO] == RESP_DEGLITCH);
        end
    end

    // =====================================================
    // timers, one per channel
    for (genvar g = 0; g < NUM_CH; g++) begin : g_timer
        ocfr_ms_timer #(.W(TIMER_W)) u_timer (
            .clock(clock),
            .resetn(resetn),
            .ms_tick(ms_tick_q),
            .start(start_d[g]),
            .units(units_d[g]),
            .done(timer_done[g])
        );
    end

    // =====================================================
    // registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                cfg_q[c] <= CFG_RESET;
                state_q[c] <= ST_OFF;
            end
            run_prev_q <= '0;
            oc_prev_q <= '0;
            oc_fault_q <= '0;
            output_enable_q <= '0;
            current_limit_q <= '0;
            alert_n_q <= 1'b1;
            ms_cnt_q <= '0;
            ms_tick_q <= 1'b0;
            cmd_ack_q <= 1'b0;
            cmd_nack_q <= 1'b0;
            cmd_rdata_q <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                cfg_q[c] <= cfg_d[c];
                state_q[c] <= state_d[c];
            end
            run_prev_q <= run_on;
            oc_prev_q <= oc_detect;
            oc_fault_q <= flag_d;
            output_enable_q <= oe_d;
            current_limit_q <= lim_d;
            alert_n_q <= alert_n_d;
            ms_cnt_q <= ms_cnt_d;
            ms_tick_q <= ms_tick_d;
            cmd_ack_q <= ack_d;
            cmd_nack_q <= nack_d;
            cmd_rdata_q <= rdata_d;
        end
    end

    // =====================================================
    // checks on channel 0
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence oc_in_run(logic [1:0] r);
        state_q[0] == ST_RUN && run_on[0] && oc_detect[0] && cfg_q[0][RESP_HI:RESP_LO] == r;
    endsequence

    // any of the events that clear the channel 0 flag
    logic clear0;
    assign clear0 = clear_faults || restore_user_all || soft_reset_command || (run_on[0] && !run_prev_q[0]);

    cfg_write_a: assert property (cmd_valid && cmd_write && cmd_page == '0 && cmd_code == CMD_OC_RESPONSE
        |=> cfg_q[0] == $past(cmd_wdata) ##1 1'b1) else $error("config write lost");
    fault_flags_a: assert property (state_q[0] == ST_RUN && oc_detect[0] && !oc_prev_q[0]
        |=> oc_fault_q[0]) else $error("fault flag not set");
    alert_drive_a: assert property (oc_fault_q[0] && !$past(alert_mask_oc[0]) |-> !alert_n_q)
        else $error("alert not asserted");
    flag_sticky_a: assert property (oc_fault_q[0] && !clear0 |=> oc_fault_q[0])
        else $error("flag dropped without clear");
    cc_limit_a: assert property (oc_in_run(RESP_CC) |=> state_q[0] == ST_RUN && current_limit_q[0])
        else $error("constant-current response left run");
    deglitch_hold_a: assert property (state_q[0] == ST_LIMIT && run_on[0] && oc_detect[0] && !timer_done[0]
        |=> state_q[0] == ST_LIMIT && output_enable_q[0]) else $error("deglitch ended early");
    shut_now_a: assert property (oc_in_run(RESP_SHUTDOWN) |=> !output_enable_q[0])
        else $error("no immediate shutdown");
    latch_off_a: assert property (state_q[0] == ST_LATCHED && run_on[0] |=> state_q[0] == ST_LATCHED)
        else $error("latched channel restarted");
    retry_run_a: assert property (state_q[0] == ST_RETRY_WAIT && run_on[0] && timer_done[0]
        |=> state_q[0] == ST_RUN && output_enable_q[0]) else $error("retry did not restart");
    zero_delay_a: assert property (oc_in_run(RESP_DEGLITCH) ##0 cfg_q[0][DELAY_HI:DELAY_LO] == 3'h0
        ##1 (state_q[0] == ST_LIMIT && run_on[0] && oc_detect[0] && cfg_q[0] == $past(cfg_q[0]))[*2]
        |=> state_q[0] != ST_LIMIT) else $error("zero delay not honoured");
endmodule : ocfr_fault_response

// file: testbench/ocfr_host_model.sv
// host-side model that issues config and status commands on the command port
`timescale 1ns/1ns
module ocfr_host_model (
    input wire logic clock,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [0:0] cmd_page,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_wdata,
    input wire logic cmd_ack_q,
    input wire logic cmd_nack_q,
    input wire logic [15:0] cmd_rdata_q
);
    // =====================================================
    // idle lines at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_page = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 8'h00;
    end
    // =====================================================
    // one command: valid for one edge, the answer is taken one cycle later
    task automatic xfer(input logic wr, input logic [0:0] pg, input logic [7:0] code, input logic [7:0] wd,
        output logic ack, output logic nack, output logic [15:0] rd);
        @(posedge clock);
        #1;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_page = pg;
        cmd_code = code;
        cmd_wdata = wd;
        @(posedge clock);
        #1;
        // answer was registered at the edge that took the command
        ack = cmd_ack_q;
        nack = cmd_nack_q;
        rd = cmd_rdata_q;
        cmd_valid = 1'b0;
        // released lines stop showing the old value
        cmd_code = ~code;
        cmd_wdata = ~wd;
    endtask : xfer
endmodule : ocfr_host_model

// file: testbench/ocfr_fault_response_tb_top.sv
// self-checking bench for the overcurrent fault response block
`timescale 1ns/1ns
module ocfr_fault_response_tb_top;
    import ocfr_pkg::*;
    localparam int CPM = 4; // clock cycles per ms, shortened
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic clear_faults = 1'b0;
    logic restore_user_all = 1'b0;
    logic soft_reset_command = 1'b0;
    logic [15:0] nvm_config = 16'h385a; // channel 0 stored value 0x5a
    logic [1:0] run_on = 2'b00;
    logic [1:0] oc_detect = 2'b00;
    logic [1:0] alert_mask_oc = 2'b00;
    logic [TIMER_W-1:0] restart_interval_setting = 16'h0002; // 2 ms between restarts
    logic cmd_valid, cmd_write, cmd_ack_q, cmd_nack_q, alert_n_q;
    logic [0:0] cmd_page;
    logic [7:0] cmd_code, cmd_wdata;
    logic [15:0] cmd_rdata_q;
    logic [1:0] output_enable_q, current_limit_q, oc_fault_q;
    int bad_count = 0;
    int compares = 0;
    int n;
    logic [31:0] ans; // ack, nack and read data of one row
    typedef struct {logic wr; logic [0:0] pg; logic [7:0] code; logic [7:0] wd; logic nk; logic [15:0] rd;} ocfr_row_type;
    ocfr_row_type rows [9] = '{
        '{1'b1, 1'b0, 8'h47, 8'ha5, 1'b0, 16'h0000}, '{1'b0, 1'b0, 8'h47, 8'h00, 1'b0, 16'h00a5},
        '{1'b1, 1'b1, 8'h47, 8'h3c, 1'b0, 16'h0000}, '{1'b0, 1'b1, 8'h47, 8'h00, 1'b0, 16'h003c},
        '{1'b0, 1'b0, 8'h47, 8'h00, 1'b0, 16'h00a5}, '{1'b1, 1'b0, 8'h78, 8'hff, 1'b1, 16'h0000},
        '{1'b0, 1'b0, 8'h10, 8'h00, 1'b1, 16'h0000}, '{1'b0, 1'b0, 8'h78, 8'h00, 1'b0, 16'h0000},
        '{1'b0, 1'b0, 8'h79, 8'h00, 1'b0, 16'h0000}};
    // =====================================================
    // clock and parts
    always #5 clock = ~clock;
    ocfr_fault_response #(.NUM_CH(2), .PAGE_W(1), .CYCLES_PER_MS(CPM)) DUT (.clock(clock), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_page(cmd_page), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .clear_faults(clear_faults), .restore_user_all(restore_user_all),
        .soft_reset_command(soft_reset_command), .nvm_config(nvm_config), .run_on(run_on),
        .oc_detect(oc_detect), .alert_mask_oc(alert_mask_oc), .restart_interval_setting(restart_interval_setting),
        .cmd_ack_q(cmd_ack_q), .cmd_nack_q(cmd_nack_q), .cmd_rdata_q(cmd_rdata_q),
        .output_enable_q(output_enable_q), .current_limit_q(current_limit_q), .oc_fault_q(oc_fault_q),
        .alert_n_q(alert_n_q));
    ocfr_host_model host (.clock(clock), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_page(cmd_page),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack_q(cmd_ack_q), .cmd_nack_q(cmd_nack_q),
        .cmd_rdata_q(cmd_rdata_q));
    // =====================================================
    // helpers
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick
    task automatic rd_chk(input logic [0:0] pg, input logic [7:0] code, input logic [15:0] exp);
        logic a, nk;
        logic [15:0] rd;
        host.xfer(1'b0, pg, code, 8'h00, a, nk, rd);
        check("read answer", {14'h0, a, nk}, 16'h0002);
        check("read data", rd, exp);
    endtask : rd_chk
    task automatic wr_cfg(input logic [0:0] pg, input logic [7:0] v);
        logic a, nk;
        logic [15:0] rd;
        host.xfer(1'b1, pg, 8'h47, v, a, nk, rd);
        check("write answer", {14'h0, a, nk}, 16'h0002);
    endtask : wr_cfg
    // one-cycle pulse: 0 clear faults, 1 soft reset, 2 restore
    task automatic pulse(input int k);
        clear_faults = (k == 0);
        soft_reset_command = (k == 1);
        restore_user_all = (k == 2);
        tick(1);
        {clear_faults, soft_reset_command, restore_user_all} = 3'h0;
        tick(1);
    endtask : pulse
    // bounded wait for channel 0 enable to reach v
    task automatic wait_oe(input logic v, input int bound, output int cnt);
        cnt = 0;
        while (output_enable_q[0] !== v) begin
            if (cnt == bound) begin
                bad_count++;
                $display("[ERR] output enable wait expected %h seen %h", v, output_enable_q[0]);
                end_sim();
            end
            tick(1);
            cnt++;
        end
    endtask : wait_oe
    // =====================================================
    // watchdog
    initial begin
        repeat (100000) @(posedge clock);
        bad_count++;
        $display("[ERR] run time expected finish seen timeout");
        end_sim();
    end
    // =====================================================
    // main sequence
    initial begin
        tick(2);
        resetn = 1'b1;
        tick(1);
        check("reset outputs", {10'h0, output_enable_q, oc_fault_q, current_limit_q}, 16'h0000);
        check("reset alert", {15'h0, alert_n_q}, 16'h0001);
        rd_chk(1'b0, 8'h47, 16'h0000);
        rd_chk(1'b1, 8'h47, 16'h0000);
        $display("test reset done");
        foreach (rows[i]) begin
            host.xfer(rows[i].wr, rows[i].pg, rows[i].code, rows[i].wd, ans[0], ans[1], ans[31:16]);
            check("row answer", {14'h0, ans[0], ans[1]}, {15'h1, rows[i].nk});
            if (!rows[i].wr && !rows[i].nk) check("row data", ans[31:16], rows[i].rd);
        end
        $display("test table done");
        // shutdown at once, no restart
        wr_cfg(1'b0, 8'hc0);
        run_on = 2'b01;
        tick(2);
        oc_detect = 2'b01;
        tick(1);
        check("shut enable", {15'h0, output_enable_q[0]}, 16'h0000);
        check("fault flag", {15'h0, oc_fault_q[0]}, 16'h0001);
        check("alert", {15'h0, alert_n_q}, 16'h0000);
        rd_chk(1'b0, 8'h78, 16'h0011);
        rd_chk(1'b0, 8'h79, 16'h4011);
        rd_chk(1'b0, 8'h7b, 16'h0080);
        oc_detect = 2'b00;
        tick(20);
        check("latched off", {14'h0, output_enable_q[0], oc_fault_q[0]}, 16'h0001);
        run_on = 2'b00;
        tick(2);
        run_on = 2'b01;
        tick(2);
        check("rerun", {14'h0, output_enable_q[0], oc_fault_q[0]}, 16'h0002);
        $display("test shutdown done");
        // constant current, delay field ignored; then each clearing command
        for (int k = 0; k < 3; k++) begin
            wr_cfg(1'b0, 8'h07);
            oc_detect = 2'b01;
            tick(1);
            check("limit", {14'h0, output_enable_q[0], current_limit_q[0]}, 16'h0003);
            if (k == 0) tick(500);
            if (k == 0) check("still on", {15'h0, output_enable_q[0]}, 16'h0001);
            oc_detect = 2'b00;
            tick(1);
            check("sticky", {15'h0, oc_fault_q[0]}, 16'h0001);
            pulse(k);
            check("cleared", {14'h0, oc_fault_q[0], alert_n_q}, 16'h0001);
            if (k > 0) rd_chk(1'b0, 8'h47, 16'h005a);
        end
        $display("test clearing done");
        // limit for the delay, then continuous restart
        wr_cfg(1'b0, 8'hb9);
        oc_detect = 2'b01;
        tick(1);
        check("deglitch limit", {14'h0, output_enable_q[0], current_limit_q[0]}, 16'h0003);
        wait_oe(1'b0, 200, n);
        check("delay range", 16'(n >= 15 * CPM && n <= 16 * CPM + 4), 16'h0001);
        oc_detect = 2'b00;
        wait_oe(1'b1, 100, n);
        check("restart range", 16'(n >= CPM && n <= 2 * CPM + 4), 16'h0001);
        oc_detect = 2'b01;
        tick(10);
        oc_detect = 2'b00;
        tick(100);
        check("glitch kept on", {14'h0, output_enable_q[0], current_limit_q[0]}, 16'h0002);
        oc_detect = 2'b01;
        wait_oe(1'b0, 200, n);
        oc_detect = 2'b00;
        wait_oe(1'b1, 100, n);
        check("second restart", 16'(n <= 2 * CPM + 4), 16'h0001);
        // zero delay field: limit for two cycles, then latch off
        wr_cfg(1'b0, 8'h80);
        oc_detect = 2'b01;
        tick(2);
        check("zero delay on", {15'h0, output_enable_q[0]}, 16'h0001);
        tick(2);
        check("zero delay off", {15'h0, output_enable_q[0]}, 16'h0000);
        oc_detect = 2'b00;
        $display("test deglitch done");
        // masked alert on channel 1
        pulse(0);
        alert_mask_oc = 2'b10;
        wr_cfg(1'b1, 8'hc0);
        run_on = 2'b11;
        tick(2);
        oc_detect = 2'b10;
        tick(1);
        check("masked", {14'h0, oc_fault_q[1], alert_n_q}, 16'h0003);
        alert_mask_oc = 2'b00;
        tick(2);
        check("unmasked", {15'h0, alert_n_q}, 16'h0000);
        $display("test mask done");
        // power cycle
        resetn = 1'b0;
        tick(1);
        resetn = 1'b1;
        tick(1);
        check("power cycle", {13'h0, oc_fault_q, alert_n_q}, 16'h0001);
        rd_chk(1'b1, 8'h47, 16'h0000);
        $display("test power cycle done");
        end_sim();
    end
endmodule : ocfr_fault_response_tb_top
